//--- rtl/mult_pipe_top.sv
// signed 18x18 multiplier with three optional pipeline stages and AXI4-Lite control
// assumes one clock, synchronous active-low reset, operands synchronous to clk
`timescale 1ns/1ps
`include "mult_pipe_map.svh"
module mult_pipe_top #(
    parameter bit USE_A_REG = 1'b1,
    parameter bit USE_B_REG = 1'b1,
    parameter bit USE_P_REG = 1'b1,
    parameter bit CLK_INV   = 1'b0
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // operands and result
    input  wire logic [17:0] a_operand,
    input  wire logic [17:0] b_operand,
    input  wire logic [17:0] b_chain_in,
    output logic      [35:0] product,
    output logic      [17:0] b_chain_out,
    // stage controls, raw pin polarity
    input  wire logic        a_reg_load_enable,
    input  wire logic        a_reg_sync_clear,
    input  wire logic        b_reg_load_enable,
    input  wire logic        b_reg_sync_clear,
    input  wire logic        product_reg_load_enable,
    input  wire logic        product_reg_sync_clear,
    // axi4-lite write address and data
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    logic [`CTRL_WIDTH-1:0] ctrl_r;
    logic                   aw_held_r;
    logic [11:0]            aw_addr_r;
    logic                   w_held_r;
    logic [31:0]            w_data_r;
    logic [3:0]             w_strb_r;

    mult_pipe_pkg::b_source_t b_src;
    mult_pipe_pkg::operand_t  b_selected;
    mult_pipe_pkg::product_t  mult_out;

    stage_ctrl_if #(.W(18)) a_st ();
    stage_ctrl_if #(.W(18)) b_st ();
    stage_ctrl_if #(.W(36)) p_st ();

    // is this offset one of ours
    function automatic logic addr_hit(input logic [11:0] addr);
        addr_hit = (addr == `CTRL_OFFSET) || (addr == `STATUS_OFFSET);
    endfunction : addr_hit

    // ---------------- datapath ----------------

    // source choice comes from a register so software can retarget a chain
    assign b_src = mult_pipe_pkg::b_source_t'(ctrl_r[`CTRL_B_SRC_BIT]);
    assign b_selected = (b_src == mult_pipe_pkg::B_SRC_CHAIN) ? b_chain_in : b_operand;

    // per-control polarity inversion: xor with the invert bit
    assign a_st.load  = a_reg_load_enable       ^ ctrl_r[`CTRL_INV_A_LOAD];
    assign a_st.clear = a_reg_sync_clear        ^ ctrl_r[`CTRL_INV_A_CLEAR];
    assign b_st.load  = b_reg_load_enable       ^ ctrl_r[`CTRL_INV_B_LOAD];
    assign b_st.clear = b_reg_sync_clear        ^ ctrl_r[`CTRL_INV_B_CLEAR];
    assign p_st.load  = product_reg_load_enable ^ ctrl_r[`CTRL_INV_P_LOAD];
    assign p_st.clear = product_reg_sync_clear  ^ ctrl_r[`CTRL_INV_P_CLEAR];

    assign a_st.d = a_operand;
    assign b_st.d = b_selected;

    // full-width signed product; 18x18 two's complement never overflows 36 bits
    assign mult_out = mult_pipe_pkg::operand_t'(a_st.q) * mult_pipe_pkg::operand_t'(b_st.q);
    assign p_st.d   = mult_out;

    // the three stages; clock inversion is static since it reshapes timing
    pipe_stage #(.USE_REG(USE_A_REG), .CLK_INV(CLK_INV)) a_stage (
        .clk  (clk),
        .rstn (rstn),
        .st   (a_st)
    );
    pipe_stage #(.USE_REG(USE_B_REG), .CLK_INV(CLK_INV)) b_stage (
        .clk  (clk),
        .rstn (rstn),
        .st   (b_st)
    );
    pipe_stage #(.USE_REG(USE_P_REG), .CLK_INV(CLK_INV)) p_stage (
        .clk  (clk),
        .rstn (rstn),
        .st   (p_st)
    );

    // outputs follow the stages; combinational when stages are bypassed
    assign product     = p_st.q;
    assign b_chain_out = b_st.q;

    // ---------------- axi4-lite write ----------------

    // address and data are accepted independently and held until the write fires
    always_ff @(posedge clk) begin
        if (!rstn) begin
            aw_held_r     <= 1'b0;
            aw_addr_r     <= 12'h000;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else if (aw_held_r && w_held_r && !s_axi_bvalid) begin
                aw_held_r <= 1'b0;
            end else if (!aw_held_r && s_axi_awvalid && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    // write data channel, mirroring the address side
    always_ff @(posedge clk) begin
        if (!rstn) begin
            w_held_r     <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (aw_held_r && w_held_r && !s_axi_bvalid) begin
                w_held_r <= 1'b0;
            end else if (!w_held_r && s_axi_wvalid && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // commit and respond once both halves are held
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r       <= `CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (s_axi_bvalid) begin
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end else if (aw_held_r && w_held_r) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_hit(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
            if (aw_addr_r == `CTRL_OFFSET && w_strb_r[0]) begin
                ctrl_r <= w_data_r[`CTRL_WIDTH-1:0];
            end
        end
    end

    // ---------------- axi4-lite read ----------------

    // status is sampled at the read, so it reflects the live product
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= addr_hit(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
                s_axi_rdata  <= 32'h0000_0000;
                if (s_axi_araddr == `CTRL_OFFSET) begin
                    s_axi_rdata[`CTRL_WIDTH-1:0] <= ctrl_r;
                end else if (s_axi_araddr == `STATUS_OFFSET) begin
                    s_axi_rdata[`STAT_P_NONZERO]  <= |p_st.q;
                    s_axi_rdata[`STAT_P_NEGATIVE] <= p_st.q[35];
                    s_axi_rdata[`STAT_A_USED]     <= USE_A_REG;
                    s_axi_rdata[`STAT_B_USED]     <= USE_B_REG;
                    s_axi_rdata[`STAT_P_USED]     <= USE_P_REG;
                end
            end else if (s_axi_arvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule : mult_pipe_top

//--- rtl/mult_pipe_map.svh
// register offsets, field positions and reset values for the pipelined multiplier
// assumes a 32-bit AXI4-Lite slave with word-aligned byte addresses
`ifndef MULT_PIPE_MAP_SVH
`define MULT_PIPE_MAP_SVH

// register byte addresses
`define CTRL_OFFSET        12'h000
`define STATUS_OFFSET      12'h004

// control register fields
`define CTRL_B_SRC_BIT     0
`define CTRL_INV_A_LOAD    1
`define CTRL_INV_A_CLEAR   2
`define CTRL_INV_B_LOAD    3
`define CTRL_INV_B_CLEAR   4
`define CTRL_INV_P_LOAD    5
`define CTRL_INV_P_CLEAR   6
`define CTRL_WIDTH         7
`define CTRL_RESET         7'h00

// status register fields
`define STAT_P_NONZERO     0
`define STAT_P_NEGATIVE    1
`define STAT_A_USED        4
`define STAT_B_USED        5
`define STAT_P_USED        6

// bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

//--- rtl/mult_pipe_pkg.sv
// types shared by the multiplier pipeline files
// assumes the map header is included by users that need offsets
package mult_pipe_pkg;
    typedef logic signed [17:0] operand_t;
    typedef logic signed [35:0] product_t;
    typedef enum logic {B_SRC_DIRECT, B_SRC_CHAIN} b_source_t;
endpackage : mult_pipe_pkg

//--- rtl/stage_ctrl_if.sv
// carrier between the multiplier top and one pipeline stage
// assumes load and clear already carry their true (post-inversion) polarity
`timescale 1ns/1ps
interface stage_ctrl_if #(
    parameter int W = 18
);
    logic         load;
    logic         clear;
    logic [W-1:0] d;
    logic [W-1:0] q;

    modport stage (input load, input clear, input d, output q);
    modport ctrl  (output load, output clear, output d, input q);
endinterface : stage_ctrl_if

//--- rtl/pipe_stage.sv
// one optional pipeline register with load enable and synchronous clear
// assumes clk is the block clock; rstn is synchronous, active low
`timescale 1ns/1ps
module pipe_stage #(
    parameter bit USE_REG = 1'b1,
    parameter bit CLK_INV = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // stage data and controls
    stage_ctrl_if.stage st
);
    logic [$bits(st.d)-1:0] hold_r;

    generate
        if (USE_REG && !CLK_INV) begin : g_rise
            // clear beats load so a stage can be flushed while enabled
            always_ff @(posedge clk) begin
                if (!rstn || st.clear) begin
                    hold_r <= '0;
                end else if (st.load) begin
                    hold_r <= st.d;
                end
            end
        end else if (USE_REG) begin : g_fall
            // inverted clock: the stage captures on the falling edge of clk
            always_ff @(negedge clk) begin
                if (!rstn || st.clear) begin
                    hold_r <= '0;
                end else if (st.load) begin
                    hold_r <= st.d;
                end
            end
        end else begin : g_bypass
            assign hold_r = st.d;
        end
    endgenerate

    // a bypassed stage is a plain wire, keeping the path combinational
    assign st.q = hold_r;
endmodule : pipe_stage

//--- tb/mult_pipe_props.sv
// checker for the multiplier block: stage loads, clears, chain output and product
// assumes all three stages used, CLK_INV=0, and ctrl written with aw and w taken together
`timescale 1ns/1ps
module mult_pipe_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // datapath
    input wire logic [17:0] a_operand,
    input wire logic [17:0] b_operand,
    input wire logic [17:0] b_chain_in,
    input wire logic [35:0] product,
    input wire logic [17:0] b_chain_out,
    // stage controls, raw pin polarity
    input wire logic        a_reg_load_enable,
    input wire logic        a_reg_sync_clear,
    input wire logic        b_reg_load_enable,
    input wire logic        b_reg_sync_clear,
    input wire logic        product_reg_load_enable,
    input wire logic        product_reg_sync_clear,
    // control write, watched to shadow the inversion bits
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb
);
    logic [6:0] ctl_r;
    logic [6:0] pend_r;
    logic       pend_v_r;
    logic       al, ac, bl, bc, pl, pc;
    // ctrl lands one edge after the bus takes it, so the shadow waits a cycle too
    always_ff @(posedge clk) begin
        pend_v_r <= rstn && s_axi_awvalid && s_axi_awready && s_axi_awaddr == 12'h000 && s_axi_wstrb[0];
        pend_r <= s_axi_wdata[6:0];
        if (!rstn) ctl_r <= 7'h00;
        else if (pend_v_r) ctl_r <= pend_r;
    end
    // controls in their true sense
    assign al = a_reg_load_enable ^ ctl_r[1];
    assign ac = a_reg_sync_clear ^ ctl_r[2];
    assign bl = b_reg_load_enable ^ ctl_r[3];
    assign bc = b_reg_sync_clear ^ ctl_r[4];
    assign pl = product_reg_load_enable ^ ctl_r[5];
    assign pc = product_reg_sync_clear ^ ctl_r[6];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_b_clear: assert property (bc |=> b_chain_out == 18'h00000)
        else $error("b stage not cleared");
    a_b_direct: assert property (bl && !bc && !ctl_r[0] |=> b_chain_out == $past(b_operand))
        else $error("b stage missed direct operand");
    a_b_chain: assert property (bl && !bc && ctl_r[0] |=> b_chain_out == $past(b_chain_in))
        else $error("b stage missed chain operand");
    a_b_hold: assert property (!bl && !bc |=> $stable(b_chain_out))
        else $error("b stage moved while idle");
    a_p_clear: assert property (pc |=> product == 36'h000000000)
        else $error("product not cleared");
    a_p_hold: assert property (!pl && !pc |=> $stable(product))
        else $error("product moved while idle");
    a_a_clear: assert property (ac ##1 (pl && !pc) |=> product == 36'h000000000)
        else $error("a stage not cleared");
    a_prod_value: assert property (al && !ac ##1 (pl && !pc)
        |=> $signed(product) == $signed($past(a_operand, 2)) * $signed($past(b_chain_out)))
        else $error("product value wrong");
endmodule : mult_pipe_props

//--- tb/fabric_model.sv
// fabric side model: drives operands and stage controls from a command word
// assumes the bench changes cmd between edges; pins move only at rising edges
`timescale 1ns/1ps
module fabric_model (
    // clock
    input  wire logic        clk,
    // command from the bench, pins toward the block
    input  wire logic [59:0] cmd,
    output logic      [59:0] pins
);
    // registered launch, like fabric flops feeding the block
    initial pins = 60'h0;
    always @(posedge clk) pins <= cmd;
endmodule : fabric_model

//--- tb/tb_top.sv
// self-checking bench for the pipelined multiplier with its control registers
// assumes default parameters: all stages used, no clock inversion
`timescale 1ns/1ps
`include "mult_pipe_map.svh"
module tb_top;
    logic        clk, rstn;
    logic [17:0] a_operand, b_operand, b_chain_in, b_chain_out;
    logic [35:0] product;
    logic        a_reg_load_enable, a_reg_sync_clear, b_reg_load_enable;
    logic        b_reg_sync_clear, product_reg_load_enable, product_reg_sync_clear;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [59:0] cmd, pins;
    int          mismatches, check_count, cyc;
    mult_pipe_top mult_pipe_top_inst (.*);
    fabric_model fabric_model_inst (.clk(clk), .cmd(cmd), .pins(pins));
    assign {a_operand, b_operand, b_chain_in, a_reg_load_enable, a_reg_sync_clear, b_reg_load_enable,
            b_reg_sync_clear, product_reg_load_enable, product_reg_sync_clear} = pins;
    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // ctl order: a load, a clear, b load, b clear, p load, p clear; waits four edges, product settles on the third
    task automatic drive(input logic [17:0] a, input logic [17:0] b, input logic [17:0] c, input logic [5:0] ctl);
        #1;
        cmd = {a, b, c, ctl};
        repeat (4) @(posedge clk);
        #1;
    endtask : drive
    task automatic axw(input logic [11:0] ad, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, er);
    endtask : axw
    task automatic axr(input logic [11:0] ad, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", s_axi_rresp, er);
    endtask : axr
    // register access: write without the byte-0 strobe, unmapped place, read-only status
    task automatic t_regs;
        axr(`CTRL_OFFSET, 32'h00000000, `RESP_OKAY);
        axr(`STATUS_OFFSET, 32'h00000070, `RESP_OKAY);
        axw(`CTRL_OFFSET, 32'h0000007F, 4'hE, `RESP_OKAY);
        axr(`CTRL_OFFSET, 32'h00000000, `RESP_OKAY);
        axw(12'h008, 32'hFFFFFFFF, 4'hF, `RESP_SLVERR);
        axr(12'h008, 32'h00000000, `RESP_SLVERR);
        axw(`STATUS_OFFSET, 32'hFFFFFFFF, 4'hF, `RESP_OKAY);
    endtask : t_regs
    // signed corner operands through all three stages
    task automatic t_mult;
        mult_pipe_pkg::operand_t av [4] = '{18'h00005, 18'h20000, 18'h3FFFF, 18'h1FFFF};
        mult_pipe_pkg::operand_t bv [4] = '{18'h1FFFF, 18'h20000, 18'h3FFFF, 18'h20000};
        mult_pipe_pkg::product_t e;
        for (int i = 0; i < 4; i++) begin
            e = av[i] * bv[i];
            drive(av[i], bv[i], ~bv[i], 6'b101010);
            chk("b_chain_out", b_chain_out, {18'h00000, $unsigned(bv[i])});
            chk("product", product, e);
        end
        axr(`STATUS_OFFSET, 32'h00000073, `RESP_OKAY);
    endtask : t_mult
    // hold with loads low, clears beating loads, a clear alone
    task automatic t_hold_clear;
        drive(18'h00003, 18'h00007, 18'h00000, 6'b000000);
        chk("b_chain_out", b_chain_out, 18'h20000);
        chk("product", product, 36'hC00020000);
        drive(18'h00003, 18'h00007, 18'h00000, 6'b111111);
        chk("b_chain_out", b_chain_out, 18'h00000);
        chk("product", product, 36'h000000000);
        drive(18'h00003, 18'h00009, 18'h00000, 6'b111010);
        chk("b_chain_out", b_chain_out, 18'h00009);
        chk("product", product, 36'h000000000);
    endtask : t_hold_clear
    // chained second operand source
    task automatic t_chain;
        axw(`CTRL_OFFSET, 32'h00000001, 4'hF, `RESP_OKAY);
        drive(18'h00002, 18'h00005, 18'h3FFFE, 6'b101010);
        chk("b_chain_out", b_chain_out, 18'h3FFFE);
        chk("product", product, 36'hFFFFFFFFC);
        axw(`CTRL_OFFSET, 32'h00000000, 4'hF, `RESP_OKAY);
    endtask : t_chain
    // every control inverted: low loads, high clears idle
    task automatic t_inv;
        axw(`CTRL_OFFSET, 32'h0000007E, 4'hF, `RESP_OKAY);
        drive(18'h00004, 18'h00006, 18'h00000, 6'b010101);
        chk("product", product, 36'h000000018);
        drive(18'h00004, 18'h00006, 18'h00000, 6'b000000);
        chk("b_chain_out", b_chain_out, 18'h00000);
        chk("product", product, 36'h000000000);
        axw(`CTRL_OFFSET, 32'h00000000, 4'hF, `RESP_OKAY);
    endtask : t_inv
    task automatic tally_and_finish;
        if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard, well above the hundred or so cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            tally_and_finish;
        end
    end
    initial begin
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, cmd} = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_mult;
        t_hold_clear;
        t_chain;
        t_inv;
        tally_and_finish;
    end
endmodule : tb_top
bind mult_pipe_top mult_pipe_props mult_pipe_props_inst (.*);
